// *** inc/cos_pkg.sv ***
// Purpose: Shared constants for the channel output select configuration block.
// Assumes: 8-bit register port, 16-bit channel and temperature data words.
// Notes:   Field positions and codes of the configuration register live here.
package cos_pkg;
   localparam logic [7:0] CFG_ADDR         = 8'h42;
   localparam logic [7:0] CFG_RESET        = 8'h00;
   localparam int         UNSIGNED_BIT     = 7;
   localparam int         SLOT0_HI         = 6;
   localparam int         SLOT0_LO         = 5;
   localparam int         SLOT1_HI         = 4;
   localparam int         SLOT1_LO         = 2;
   localparam int         AVG_HI           = 1;
   localparam int         AVG_LO           = 0;
   localparam int         DATA_W           = 16;
   localparam logic [1:0] AVG_BYPASS       = 2'h0;
   // Moving average input sample periods in microseconds, codes 1 to 3.
   localparam int         AVG_PERIOD0_US   = 32;
   localparam int         AVG_PERIOD1_US   = 64;
   localparam int         AVG_PERIOD2_US   = 128;
   localparam int         AVG_SAMPLES      = 8;
   localparam logic [1:0] SLOT0_OC         = 2'h0;
   localparam logic [1:0] SLOT0_RAW        = 2'h1;
   localparam logic [2:0] SLOT1_OC_AVG     = 3'h0;
   localparam logic [2:0] SLOT1_RAW_AVG    = 3'h1;
   localparam logic [2:0] SLOT1_OC_NOAVG   = 3'h4;
   localparam logic [2:0] SLOT1_RAW_AVG2   = 3'h5;
   localparam logic [DATA_W-1:0] SIGN_FLIP = 16'h8000;
   typedef enum logic [1:0] {COS_SRC_OC, COS_SRC_RAW, COS_SRC_TEMP} cos_src_t;
endpackage

// *** src/cos_slot_mux.sv ***
// Purpose: Picks and formats the data for one result register pair.
// Assumes: Inputs are signed two's complement samples on the same clock.
// Notes:   Temperature passes untouched; only acceleration is re-based.
`timescale 1ns/100ps
module cos_slot_mux
(
   // Selection
   input  wire cos_pkg::cos_src_t         src,
   input  wire logic                      use_avg,
   input  wire logic                      use_interp,
   input  wire logic                      unsigned_sel,
   // Data sources
   input  wire logic [cos_pkg::DATA_W-1:0] accel_oc,
   input  wire logic [cos_pkg::DATA_W-1:0] accel_raw,
   input  wire logic [cos_pkg::DATA_W-1:0] accel_oc_avg,
   input  wire logic [cos_pkg::DATA_W-1:0] accel_raw_avg,
   input  wire logic [cos_pkg::DATA_W-1:0] accel_oc_interp,
   input  wire logic [cos_pkg::DATA_W-1:0] accel_raw_interp,
   input  wire logic [cos_pkg::DATA_W-1:0] temp_data,
   // Result
   output logic      [cos_pkg::DATA_W-1:0] result
);
   logic [cos_pkg::DATA_W-1:0] acc;

   always_comb
   begin
      acc = accel_raw;
      case (src)
         cos_pkg::COS_SRC_OC:
         begin
            if (use_avg)
               acc = accel_oc_avg;
            else if (use_interp)
               acc = accel_oc_interp;
            else
               acc = accel_oc;
         end
         default:
         begin
            if (use_avg)
               acc = accel_raw_avg;
            else if (use_interp)
               acc = accel_raw_interp;
            else
               acc = accel_raw;
         end
      endcase
      // sign format
      // Offset binary is the signed word with its sign bit flipped.
      if (src == cos_pkg::COS_SRC_TEMP)
         result = temp_data;
      else if (unsigned_sel)
         result = acc ^ cos_pkg::SIGN_FLIP;
      else
         result = acc;
   end
endmodule

// *** src/cos_config.sv ***
// Overview of operation
// - An 8-bit configuration register at address 0x42 is readable and writable in every mode.
// - The register contents feed the read/write array error-detection check.
// - The register is user programmed and reads all zero in the unprogrammed state.
// - Bit 7 is unsigned select, bits 6:5 slot0 content, 4:2 slot1 content, 1:0 averaging.
// - Acceleration results are signed when unsigned select is 0 and unsigned when 1.
// - Temperature results keep their own format regardless of unsigned select.
// - The slot0 content field chooses what goes into the first result pair.
// - Slot0 code 00 gives acceleration with offset cancel, averaging and interpolation per setup.
// - Slot0 code 01 gives uncancelled acceleration and codes 10 and 11 give temperature.
// - The slot1 content field chooses the second result pair, which is never interpolated.
// - Slot1 code 000 gives cancelled averaged data and 001 the same without cancellation.
// - Slot1 code 100 is cancelled without averaging, 101 uncancelled averaged, rest temperature.
// - Averaging code 00 bypasses averaging with interpolation, others average 8 samples.
// - Any change of the averaging field pulses the DSP path reset for one cycle and holds results invalid until it reinitialises.
//
// Purpose: Holds the channel output select register and steers the result muxes.
// Assumes: Mode-independent register port shared by all serial front ends.
// Notes:   Offset cancellation on or off comes from its own register as an input.
`timescale 1ns/100ps
module cos_config
(
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       reset,
   // Register port
   input  wire logic [7:0]                 reg_addr,
   input  wire logic                       reg_wr,
   input  wire logic [7:0]                 reg_wdata,
   output logic      [7:0]                 reg_rdata,
   output logic                            reg_hit,
   // OTP image load
   input  wire logic                       otp_load,
   input  wire logic [7:0]                 otp_data,
   // Error detection view
   output logic      [7:0]                 cfg_image,
   // DSP control
   input  wire logic                       oc_filter_enable,
   input  wire logic                       dsp_init_done,
   output logic                            dsp_path_reset,
   output logic                            avg_enable,
   output logic                            interp_enable,
   output logic      [1:0]                 avg_period_code,
   // Data sources
   input  wire logic [cos_pkg::DATA_W-1:0] accel_oc,
   input  wire logic [cos_pkg::DATA_W-1:0] accel_raw,
   input  wire logic [cos_pkg::DATA_W-1:0] accel_oc_avg,
   input  wire logic [cos_pkg::DATA_W-1:0] accel_raw_avg,
   input  wire logic [cos_pkg::DATA_W-1:0] accel_oc_interp,
   input  wire logic [cos_pkg::DATA_W-1:0] accel_raw_interp,
   input  wire logic [cos_pkg::DATA_W-1:0] temp_data,
   // Results
   output logic      [cos_pkg::DATA_W-1:0] first_result_pair,
   output logic      [cos_pkg::DATA_W-1:0] second_result_pair,
   output logic                            results_valid
);
   // Results are registered so the pairs never glitch while a selection changes.
   typedef struct packed {
      logic [7:0]                 cfg;
      logic                       rst_pend;
      logic                       busy;
      logic [cos_pkg::DATA_W-1:0] res0;
      logic [cos_pkg::DATA_W-1:0] res1;
   } cos_state_t;

   cos_state_t s_r;
   cos_state_t s_nxt;

   logic                       unsigned_sel;
   logic [1:0]                 slot0_sel;
   logic [2:0]                 slot1_sel;
   logic [1:0]                 avg_sel;
   logic                       avg_on;
   cos_pkg::cos_src_t          src0;
   cos_pkg::cos_src_t          src1;
   logic                       avg1;
   logic [cos_pkg::DATA_W-1:0] mux0;
   logic [cos_pkg::DATA_W-1:0] mux1;
   logic                       cfg_wr;

   // A write is taken on any edge where the strobe is high at this address and no OTP load is active.
   assign cfg_wr = reg_wr && (reg_addr == cos_pkg::CFG_ADDR);

   assign unsigned_sel = s_r.cfg[cos_pkg::UNSIGNED_BIT];
   assign slot0_sel    = s_r.cfg[cos_pkg::SLOT0_HI:cos_pkg::SLOT0_LO];
   assign slot1_sel    = s_r.cfg[cos_pkg::SLOT1_HI:cos_pkg::SLOT1_LO];
   assign avg_sel      = s_r.cfg[cos_pkg::AVG_HI:cos_pkg::AVG_LO];

   // The period code is only passed on; the averaging itself sits upstream.
   // averaging versus interpolation
   assign avg_on          = (avg_sel != cos_pkg::AVG_BYPASS);
   assign avg_enable      = avg_on;
   assign interp_enable   = !avg_on;
   assign avg_period_code = avg_sel;

   // With offset cancellation off, code 00 falls back to the uncancelled samples.
   // slot0 decode
   always_comb
   begin
      case (slot0_sel)
         cos_pkg::SLOT0_OC:  src0 = oc_filter_enable ? cos_pkg::COS_SRC_OC : cos_pkg::COS_SRC_RAW;
         cos_pkg::SLOT0_RAW: src0 = cos_pkg::COS_SRC_RAW;
         default:            src0 = cos_pkg::COS_SRC_TEMP;
      endcase
   end

   // Codes 001 and 101 select the same data; both follow the averaging field.
   // slot1 decode
   always_comb
   begin
      avg1 = avg_on;
      case (slot1_sel)
         cos_pkg::SLOT1_OC_AVG:
            src1 = oc_filter_enable ? cos_pkg::COS_SRC_OC : cos_pkg::COS_SRC_RAW;
         cos_pkg::SLOT1_OC_NOAVG:
         begin
            src1 = oc_filter_enable ? cos_pkg::COS_SRC_OC : cos_pkg::COS_SRC_RAW;
            avg1 = 1'b0;
         end
         cos_pkg::SLOT1_RAW_AVG,
         cos_pkg::SLOT1_RAW_AVG2:
            src1 = cos_pkg::COS_SRC_RAW;
         default:
            src1 = cos_pkg::COS_SRC_TEMP;
      endcase
   end

   cos_slot_mux u_slot0
   (
      .src              (src0),
      .use_avg          (avg_on),
      .use_interp       (!avg_on),
      .unsigned_sel     (unsigned_sel),
      .accel_oc         (accel_oc),
      .accel_raw        (accel_raw),
      .accel_oc_avg     (accel_oc_avg),
      .accel_raw_avg    (accel_raw_avg),
      .accel_oc_interp  (accel_oc_interp),
      .accel_raw_interp (accel_raw_interp),
      .temp_data        (temp_data),
      .result           (mux0)
   );

   cos_slot_mux u_slot1
   (
      .src              (src1),
      .use_avg          (avg1),
      .use_interp       (1'b0),
      .unsigned_sel     (unsigned_sel),
      .accel_oc         (accel_oc),
      .accel_raw        (accel_raw),
      .accel_oc_avg     (accel_oc_avg),
      .accel_raw_avg    (accel_raw_avg),
      .accel_oc_interp  (accel_oc_interp),
      .accel_raw_interp (accel_raw_interp),
      .temp_data        (temp_data),
      .result           (mux1)
   );

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rst_pend = 1'b0;
      if (otp_load)
         s_nxt.cfg = otp_data;
      else if (cfg_wr)
         s_nxt.cfg = reg_wdata;
      // Comparing the next value catches OTP reloads as well as bus writes.
      // averaging change restarts DSP
      if (s_nxt.cfg[cos_pkg::AVG_HI:cos_pkg::AVG_LO] != avg_sel)
      begin
         s_nxt.rst_pend = 1'b1;
         s_nxt.busy     = 1'b1;
      end
      else if (dsp_init_done && !s_r.rst_pend)
         s_nxt.busy = 1'b0;
      s_nxt.res0 = mux0;
      s_nxt.res1 = mux1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         s_r.cfg      <= cos_pkg::CFG_RESET;
         s_r.rst_pend <= 1'b0;
         s_r.busy     <= 1'b0;
         s_r.res0     <= '0;
         s_r.res1     <= '0;
      end
      else
         s_r <= s_nxt;
   end

   // Reads of other addresses return zero so several banks can share one read bus.
   // readback
   assign reg_hit   = (reg_addr == cos_pkg::CFG_ADDR);
   assign reg_rdata = reg_hit ? s_r.cfg : 8'h00;
   assign cfg_image          = s_r.cfg;
   assign dsp_path_reset     = s_r.rst_pend;
   assign first_result_pair  = s_r.res0;
   assign second_result_pair = s_r.res1;
   // Results stay flagged invalid from an averaging change until the DSP reports ready.
   assign results_valid      = !s_r.busy;

   // Result checks use the sources of the cycle before, since both pairs are registered.
   // The reset check has no disable condition, since it looks at the release edge itself.

   a_write_takes: assert property (@(posedge sys_clk) disable iff (reset)
      (cfg_wr && !otp_load) |=> (reg_rdata == $past(reg_wdata) || !reg_hit));

   a_image_write: assert property (@(posedge sys_clk) disable iff (reset)
      (cfg_wr && !otp_load) |=> (cfg_image == $past(reg_wdata)));

   a_other_addr: assert property (@(posedge sys_clk) disable iff (reset)
      (reg_wr && !otp_load && reg_addr != cos_pkg::CFG_ADDR) |=> $stable(cfg_image));

   a_reset_clear: assert property (@(posedge sys_clk)
      $fell(reset) |-> (cfg_image == cos_pkg::CFG_RESET && results_valid && !dsp_path_reset));

   a_otp_load: assert property (@(posedge sys_clk) disable iff (reset)
      otp_load |=> (cfg_image == $past(otp_data)));

   a_avg_restart: assert property (@(posedge sys_clk) disable iff (reset)
      (avg_sel != $past(avg_sel)) |-> (dsp_path_reset && !results_valid));

   a_pulse_single: assert property (@(posedge sys_clk) disable iff (reset)
      (dsp_path_reset && !otp_load && !cfg_wr) |=> !dsp_path_reset);

   a_valid_hold: assert property (@(posedge sys_clk) disable iff (reset)
      (!results_valid && !dsp_init_done) |=> !results_valid);

   a_valid_return: assert property (@(posedge sys_clk) disable iff (reset)
      (!results_valid && !dsp_path_reset && dsp_init_done && !otp_load && !cfg_wr)
      |=> results_valid);

   a_interp_excl: assert property (@(posedge sys_clk) disable iff (reset)
      avg_enable == (avg_period_code != cos_pkg::AVG_BYPASS) && (interp_enable != avg_enable));

   a_temp_slot0: assert property (@(posedge sys_clk) disable iff (reset)
      (slot0_sel[1] && $stable(temp_data) && $stable(s_r.cfg))
      |=> first_result_pair == $past(temp_data));

   a_temp_slot1: assert property (@(posedge sys_clk) disable iff (reset)
      (slot1_sel[1] && $stable(temp_data) && $stable(s_r.cfg))
      |=> second_result_pair == $past(temp_data));

   a_raw_slot0: assert property (@(posedge sys_clk) disable iff (reset)
      (slot0_sel == cos_pkg::SLOT0_RAW && !avg_on && !unsigned_sel && $stable(accel_raw_interp)
       && $stable(s_r.cfg)) |=> first_result_pair == $past(accel_raw_interp));

   a_oc_interp0: assert property (@(posedge sys_clk) disable iff (reset)
      (slot0_sel == cos_pkg::SLOT0_OC && oc_filter_enable && !avg_on && !unsigned_sel)
      |=> first_result_pair == $past(accel_oc_interp));

   a_oc_off0: assert property (@(posedge sys_clk) disable iff (reset)
      (slot0_sel == cos_pkg::SLOT0_OC && !oc_filter_enable && avg_on && !unsigned_sel)
      |=> first_result_pair == $past(accel_raw_avg));

   a_unsigned_flip: assert property (@(posedge sys_clk) disable iff (reset)
      (slot1_sel == cos_pkg::SLOT1_RAW_AVG && !avg_on && unsigned_sel && $stable(accel_raw)
       && $stable(s_r.cfg)) |=> second_result_pair == ($past(accel_raw) ^ cos_pkg::SIGN_FLIP));

   a_oc_avg1: assert property (@(posedge sys_clk) disable iff (reset)
      (slot1_sel == cos_pkg::SLOT1_OC_AVG && oc_filter_enable && avg_on && !unsigned_sel)
      |=> second_result_pair == $past(accel_oc_avg));

   a_raw_avg1: assert property (@(posedge sys_clk) disable iff (reset)
      (slot1_sel == cos_pkg::SLOT1_RAW_AVG2 && avg_on && !unsigned_sel)
      |=> second_result_pair == $past(accel_raw_avg));

   a_no_interp1: assert property (@(posedge sys_clk) disable iff (reset)
      (slot1_sel == cos_pkg::SLOT1_OC_NOAVG && oc_filter_enable && !unsigned_sel
       && $stable(accel_oc) && $stable(s_r.cfg)) |=> second_result_pair == $past(accel_oc));
endmodule

// *** tb/channel_output_select_config_tb_top.sv ***
// Purpose: Self-checking bench for the channel output select register block.
// Assumes: Inputs change 1 ns after the rising edge; checks sample there too.
// Notes:   Expected results are rebuilt here from the field codes and the offset cancel enable.
`timescale 1ns/100ps
module channel_output_select_config_tb_top;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  reg_addr = 8'h42;
   logic        reg_wr = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        otp_load = 1'b0;
   logic [7:0]  otp_data = 8'h00;
   logic        oc_filter_enable = 1'b0;
   logic        dsp_init_done = 1'b1;
   logic [15:0] src [0:6] = '{default: 16'h0000};
   logic [7:0]  reg_rdata, cfg_image;
   logic        reg_hit, dsp_path_reset, avg_enable, interp_enable, results_valid;
   logic [1:0]  avg_period_code;
   logic [15:0] first_result_pair, second_result_pair;
   int          err_count = 0;
   int          n_checks = 0;

   always #12.5 sys_clk = ~sys_clk;

   cos_config DUT
   (
      .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .otp_load(otp_load), .otp_data(otp_data), .cfg_image(cfg_image),
      .oc_filter_enable(oc_filter_enable), .dsp_init_done(dsp_init_done),
      .dsp_path_reset(dsp_path_reset), .avg_enable(avg_enable),
      .interp_enable(interp_enable), .avg_period_code(avg_period_code),
      .accel_oc(src[0]), .accel_raw(src[1]), .accel_oc_avg(src[2]),
      .accel_raw_avg(src[3]), .accel_oc_interp(src[4]), .accel_raw_interp(src[5]),
      .temp_data(src[6]), .first_result_pair(first_result_pair),
      .second_result_pair(second_result_pair), .results_valid(results_valid)
   );

   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
   endtask

   // Temperature is passed as is; only acceleration is re-based to offset binary.
   function automatic logic [15:0] pick(logic oc, logic av, logic itp, logic tmp, logic uns);
      logic [15:0] v;
      if (tmp)
         return src[6];
      v = av ? (oc ? src[2] : src[3]) : itp ? (oc ? src[4] : src[5]) : (oc ? src[0] : src[1]);
      return uns ? v ^ cos_pkg::SIGN_FLIP : v;
   endfunction

   task automatic t_reset;
      chk("rdata", 16'h0000, {8'h00, reg_rdata});
      chk("hit", 16'h0001, {15'h0000, reg_hit});
      chk("image", 16'h0000, {8'h00, cfg_image});
      chk("valid_pulse", 16'h0002, {14'h0000, results_valid, dsp_path_reset});
   endtask

   task automatic t_access;
      wr(8'h41, 8'hFF);
      reg_addr = 8'h41;
      tick(1);
      chk("rdata_other", 16'h0000, {8'h00, reg_rdata});
      chk("hit_other", 16'h0000, {15'h0000, reg_hit});
      reg_addr = 8'h42;
      tick(1);
      chk("rdata_kept", 16'h0000, {8'h00, reg_rdata});
      otp_load = 1'b1;
      otp_data = 8'h3C;
      wr(8'h42, 8'h5A);
      otp_load = 1'b0;
      chk("rdata_otp", 16'h003C, {8'h00, reg_rdata});
      tick(1);
      reg_wdata = 8'hA5;
      reg_wr = 1'b1;
      tick(1);
      reg_wdata = 8'h96;
      tick(1);
      reg_wr = 1'b0;
      chk("rdata_b2b", 16'h0096, {8'h00, reg_rdata});
      tick(1);
   endtask

   task automatic t_sweep;
      logic [7:0] c;
      for (int oe = 0; oe < 2; oe++)
         for (int i = 0; i < 256; i++)
         begin
            c = i[7:0];
            oc_filter_enable = oe[0];
            for (int j = 0; j < 7; j++)
               src[j] = 16'(j * 16'h2345) ^ {c, ~c};
            wr(8'h42, c);
            chk("rdata", {8'h00, c}, {8'h00, reg_rdata});
            chk("image", {8'h00, c}, {8'h00, cfg_image});
            chk("avg_ctrl", {12'h000, c[1:0] != 2'h0, c[1:0] == 2'h0, c[1:0]},
                {12'h000, avg_enable, interp_enable, avg_period_code});
            tick(1);
            chk("first_pair", pick(c[6:5] == 2'h0 && oe[0], c[1:0] != 2'h0,
                c[1:0] == 2'h0, c[6], c[7]), first_result_pair);
            chk("second_pair", pick(!c[2] && oe[0], c[1:0] != 2'h0 && c[4:2] != 3'h4,
                1'b0, c[3], c[7]), second_result_pair);
         end
   endtask

   task automatic t_dsp;
      int k;
      dsp_init_done = 1'b0;
      wr(8'h42, 8'h7D);
      chk("pulse_valid", 16'h0001, {14'h0000, results_valid, dsp_path_reset});
      tick(1);
      chk("pulse_end", 16'h0000, {14'h0000, results_valid, dsp_path_reset});
      tick(3);
      chk("valid_held", 16'h0000, {15'h0000, results_valid});
      dsp_init_done = 1'b1;
      k = 0;
      while (results_valid !== 1'b1 && k < 4)
      begin
         tick(1);
         k++;
      end
      if (k == 4)
      begin
         $display("[ERR] results_valid expected 1 seen %b", results_valid);
         err_count++;
         final_report;
      end
      wr(8'h42, 8'h81);
      chk("no_pulse", 16'h0002, {14'h0000, results_valid, dsp_path_reset});
   endtask

   task automatic t_hold;
      tick(1);
      oc_filter_enable = 1'b1;
      wr(8'h42, 8'h20);
      tick(2);
      chk("raw_interp", src[5], first_result_pair);
      wr(8'h42, 8'h84);
      tick(2);
      chk("raw_unsigned", src[1] ^ cos_pkg::SIGN_FLIP, second_result_pair);
      wr(8'h42, 8'h10);
      tick(2);
      chk("oc_no_interp", src[0], second_result_pair);
      reset = 1'b1;
      tick(2);
      reset = 1'b0;
      tick(1);
      chk("rdata_rst", 16'h0000, {8'h00, reg_rdata});
      chk("valid_rst", 16'h0002, {14'h0000, results_valid, dsp_path_reset});
   endtask

   task final_report;
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      t_reset;
      t_access;
      t_sweep;
      t_dsp;
      t_hold;
      final_report;
   end
endmodule
